// ==== core/dual_timer_with_pwm.sv ====
// two 8-bit timers, cascadable to 16 bits, and a 3-channel 10-bit pwm
// assumes apb master on clk; pins asynchronous; isr_ack from same clock
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "dual_timer_consts.svh"

module dual_timer_with_pwm
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        first_capture_in,
  input  wire logic        second_capture_in,
  input  wire logic        first_ext_clock_in,
  input  wire logic        sub_clock_in,
  output logic             first_toggle_out,
  output logic             second_toggle_out,
  output logic             chan_a_out,
  output logic             chan_b_out,
  output logic             chan_c_out,
  // interrupt requests and service acknowledge
  input  wire logic [3:0]  isr_ack,
  output logic [3:0]       irq_req
);

  dual_timer_pkg::state_t q;
  dual_timer_pkg::state_t next_q;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic div_tick(input logic [3:0]  code,
                                    input logic [31:0] table_,
                                    input logic [10:0] presc);
    logic [3:0]  s;
    logic [10:0] mask;
    s    = table_[{code[2:0], 2'b00} +: 4];
    mask = 11'((12'h001 << s) - 12'h001);
    return (presc & mask) == mask;
  endfunction

  // one 8-bit timer step; capture beats count, match only in interval
  function automatic dual_timer_pkg::step_t step8(input logic [7:0] cnt,
                                                 input logic [7:0] buf_,
                                                 input logic [7:0] dat,
                                                 input logic       cap,
                                                 input logic       evt,
                                                 input logic       tick);
    dual_timer_pkg::step_t r;
    r.cnt   = cnt;
    r.dat   = dat;
    r.buf_  = buf_;
    r.match = 1'b0;
    r.ovf   = 1'b0;
    if (cap && evt)
    begin
      r.dat = cnt;
      r.cnt = 8'h00;
    end
    else if (tick)
    begin
      if (!cap && cnt == buf_)
      begin
        r.cnt   = 8'h00;
        r.match = 1'b1;
        r.buf_  = dat;
      end
      else
      begin
        r.cnt = cnt + 8'h01;
        if (cap && cnt == `CNT_MAX8)
        begin
          r.ovf  = 1'b1;
          r.buf_ = dat;
        end
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decoded conditions

  logic [7:0]  idx;
  logic        wr;
  logic [7:0]  wd;
  logic        casc;
  logic        cap1;
  logic        cap2;
  logic        pwm_on;
  logic        eclk_rise;
  logic        eclk_fall;
  logic        sclk_rise;
  logic        cap1_evt;
  logic        cap2_evt;
  logic        tick1;
  logic        tick2;
  logic        clear1;
  logic        clear2;
  logic [9:0]  period;
  logic        end_p;
  logic [29:0] duty_now;

  assign idx    = paddr[9:2];
  assign wr     = psel && penable && pwrite;
  assign wd     = pwdata[7:0];
  assign casc   = q.ctl1[`CTL_CASCADE];
  assign cap1   = q.ctl1[`CTL_CAPTURE];
  assign cap2   = q.ctl2[`CTL_CAPTURE];
  assign pwm_on = q.pwm_ctl[`PWM_SEL];
  assign eclk_rise = q.eclk_s[1] && !q.eclk_s[2];
  assign eclk_fall = !q.eclk_s[1] && q.eclk_s[2];
  assign sclk_rise = q.sclk_s[1] && !q.sclk_s[2];
  // edge choice per timer
  assign cap1_evt = q.ctl1[`CTL_CAP_FALL] ?
                    (!q.cap1_s[1] && q.cap1_s[2]) :
                    (q.cap1_s[1] && !q.cap1_s[2]);
  assign cap2_evt = q.ctl2[`CTL_CAP_FALL] ?
                    (!q.cap2_s[1] && q.cap2_s[2]) :
                    (q.cap2_s[1] && !q.cap2_s[2]);
  assign clear1 = wr && idx == `IDX_FIRST_CTL && wd[`CTL_CLEAR];
  assign clear2 = wr && idx == `IDX_SECOND_CTL && wd[`CTL_CLEAR];

  always_comb
  begin
    logic [3:0] c1;
    logic [3:0] c2;
    c1 = q.ctl1[`CTL_CS_MSB:0];
    c2 = q.ctl2[`CTL_CS_MSB:0];
    tick1 = c1[3] ? div_tick(c1, `FIRST_DIV_SHIFTS, q.presc) :
            (c1 == `CS_EXT_RISE && eclk_rise) ||
            (c1 == `CS_EXT_FALL && eclk_fall) ||
            (c1 == `CS_SUB && sclk_rise);
    // no external clock pin on the second timer
    tick2 = c2[3] ? div_tick(c2, `SECOND_DIV_SHIFTS, q.presc) :
            (c2 == `CS_SUB && sclk_rise);
  end

  assign period   = {q.pwm_ext[`EXT_PERIOD_LSB +: 2], q.dat1};
  assign end_p    = tick1 && q.pwm_cnt >= period;
  assign duty_now = {q.pwm_ext[`EXT_DUTY_C_LSB +: 2], q.duty_c,
                     q.pwm_ext[`EXT_DUTY_B_LSB +: 2], q.duty_b,
                     q.pwm_ext[`EXT_DUTY_A_LSB +: 2], q.duty_a};

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    dual_timer_pkg::step_t s1;
    dual_timer_pkg::step_t s2;
    logic [15:0] c16;
    logic [3:0]  set;
    logic [3:0]  clr;
    logic [9:0]  d;
    next_q = q;
    s1  = '0;
    s2  = '0;
    c16 = {q.cnt2, q.cnt1};
    set = 4'h0;
    clr = isr_ack;
    d   = 10'h000;
    next_q.presc  = q.presc + 11'h001;
    next_q.cap1_s = {q.cap1_s[1:0], first_capture_in};
    next_q.cap2_s = {q.cap2_s[1:0], second_capture_in};
    next_q.eclk_s = {q.eclk_s[1:0], first_ext_clock_in};
    next_q.sclk_s = {q.sclk_s[1:0], sub_clock_in};

    // apb writes
    if (wr)
    begin
      case (idx)
        `IDX_FIRST_DATA:  next_q.dat1 = wd;
        `IDX_SECOND_DATA: next_q.dat2 = wd;
        `IDX_FIRST_CTL:   next_q.ctl1 = wd & `CTL_WMASK;
        `IDX_SECOND_CTL:  next_q.ctl2 = wd & `CTL_WMASK;
        `IDX_PWM_CTL:     next_q.pwm_ctl = wd[7:`PWM_CTL_LSB];
        `IDX_PWM_EXT:     next_q.pwm_ext = wd;
        `IDX_DUTY_A:      next_q.duty_a = wd;
        `IDX_DUTY_B:      next_q.duty_b = wd;
        `IDX_DUTY_C:      next_q.duty_c = wd;
        `IDX_IRQ_FLAGS:   clr = clr | wd[3:0];
        default:          next_q.prdata = q.prdata;
      endcase
    end

    // first timer, or cascaded pair
    if (clear1)
    begin
      next_q.cnt1 = 8'h00;
      next_q.buf1 = q.dat1;
      if (casc)
      begin
        next_q.cnt2 = 8'h00;
        next_q.buf2 = q.dat2;
      end
    end
    else if (!pwm_on && casc)
    begin
      if (cap1 && cap1_evt)
      begin
        next_q.dat1 = q.cnt1;
        next_q.dat2 = q.cnt2;
        next_q.cnt1 = 8'h00;
        next_q.cnt2 = 8'h00;
      end
      else if (tick1)
      begin
        if (!cap1 && c16 == {q.buf2, q.buf1})
        begin
          next_q.cnt1 = 8'h00;
          next_q.cnt2 = 8'h00;
          next_q.tog1 = !q.tog1;
          set[`FLG_FIRST_MATCH] = 1'b1;
          next_q.buf1 = q.dat1;
          next_q.buf2 = q.dat2;
        end
        else
        begin
          {next_q.cnt2, next_q.cnt1} = c16 + 16'h0001;
          if (cap1 && c16 == `CNT_MAX16)
          begin
            set[`FLG_FIRST_OVF] = 1'b1;
            next_q.buf1 = q.dat1;
            next_q.buf2 = q.dat2;
          end
        end
      end
    end
    else if (!pwm_on)
    begin
      s1 = step8(q.cnt1, q.buf1, next_q.dat1, cap1, cap1_evt, tick1);
      next_q.cnt1 = s1.cnt;
      next_q.dat1 = s1.dat;
      next_q.buf1 = s1.buf_;
      next_q.tog1 = q.tog1 ^ s1.match;
      set[`FLG_FIRST_MATCH] = s1.match;
      set[`FLG_FIRST_OVF]   = s1.ovf;
    end

    // second timer, free only when not cascaded
    if (clear2 && !casc)
    begin
      next_q.cnt2 = 8'h00;
      next_q.buf2 = q.dat2;
    end
    else if (!casc)
    begin
      s2 = step8(q.cnt2, q.buf2, next_q.dat2, cap2, cap2_evt, tick2);
      next_q.cnt2 = s2.cnt;
      next_q.dat2 = s2.dat;
      next_q.buf2 = s2.buf_;
      next_q.tog2 = q.tog2 ^ s2.match;
      set[`FLG_SECOND_MATCH] = s2.match;
      set[`FLG_SECOND_OVF]   = s2.ovf;
    end

    // set beats clear so no event is lost
    next_q.flags = (q.flags & ~clr) | set;

    // pwm: duties latch only at period end, period is live
    if (pwm_on)
    begin
      if (tick1)
        next_q.pwm_cnt = end_p ? 10'h000 : q.pwm_cnt + 10'h001;
      if (end_p)
        next_q.duty_sh = duty_now;
    end
    else
    begin
      next_q.pwm_cnt = 10'h000;
      next_q.duty_sh = duty_now;
    end
    for (int i = 0; i < 3; i++)
    begin
      d = q.duty_sh[i*10 +: 10];
      // zero duty never active, duty at period always active
      next_q.pwm_out[i] = (pwm_on && d != 10'h000 && q.pwm_cnt <= d) ?
                          q.pwm_ctl[`PWM_POL_A + i] :
                          !q.pwm_ctl[`PWM_POL_A + i];
    end

    // read data captured in the setup cycle, held through access
    if (psel && !penable)
    begin
      next_q.slverr = 1'b0;
      case (idx)
        `IDX_FIRST_DATA:   next_q.prdata = {24'h0, q.dat1};
        `IDX_FIRST_COUNT:  next_q.prdata = {24'h0, q.cnt1};
        `IDX_SECOND_DATA:  next_q.prdata = {24'h0, q.dat2};
        `IDX_SECOND_COUNT: next_q.prdata = {24'h0, q.cnt2};
        `IDX_FIRST_CTL:    next_q.prdata = {24'h0, q.ctl1};
        `IDX_SECOND_CTL:   next_q.prdata = {24'h0, q.ctl2};
        `IDX_PWM_CTL:      next_q.prdata = {24'h0, q.pwm_ctl, 4'h0};
        `IDX_PWM_EXT:      next_q.prdata = {24'h0, q.pwm_ext};
        `IDX_DUTY_A:       next_q.prdata = {24'h0, q.duty_a};
        `IDX_DUTY_B:       next_q.prdata = {24'h0, q.duty_b};
        `IDX_DUTY_C:       next_q.prdata = {24'h0, q.duty_c};
        `IDX_IRQ_FLAGS:    next_q.prdata = {28'h0, q.flags};
        default:
        begin
          next_q.prdata = 32'h0000_0000;
          next_q.slverr = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q         <= '0;
      q.dat1    <= `RST_DATA;
      q.dat2    <= `RST_DATA;
      q.buf1    <= `RST_DATA;
      q.buf2    <= `RST_DATA;
      q.ctl1    <= `RST_CTL;
      q.ctl2    <= `RST_CTL;
      q.pwm_ctl <= `RST_PWM_CTL;
      q.pwm_ext <= `RST_PWM_EXT;
      q.duty_a  <= `RST_DUTY;
      q.duty_b  <= `RST_DUTY;
      q.duty_c  <= `RST_DUTY;
      q.pwm_out <= 3'h0;
    end
    else
      q <= next_q;
  end

  // zero wait states; error flag only meaningful in the access phase
  assign pready            = 1'b1;
  assign prdata            = q.prdata;
  assign pslverr           = q.slverr && psel && penable;
  assign first_toggle_out  = q.tog1;
  assign second_toggle_out = q.tog2;
  assign chan_a_out        = q.pwm_out[0];
  assign chan_b_out        = q.pwm_out[1];
  assign chan_c_out        = q.pwm_out[2];
  assign irq_req           = q.flags;

  ////////////////////////////////////////////////////////////////////////
  // checks

  first_match_a: assert property (@(posedge clk) disable iff (rst)
    (!pwm_on && !casc && !cap1 && !clear1 && tick1 && q.cnt1 == q.buf1)
    |=> (q.cnt1 == 8'h00 && q.tog1 != $past(q.tog1) &&
         q.flags[`FLG_FIRST_MATCH]))
    else $error("first timer match did not clear, toggle and flag");

  first_capture_a: assert property (@(posedge clk) disable iff (rst)
    (!pwm_on && !casc && cap1 && !clear1 && cap1_evt)
    |=> (q.dat1 == $past(q.cnt1) && q.cnt1 == 8'h00))
    else $error("first capture did not copy and clear");

  first_ovf_a: assert property (@(posedge clk) disable iff (rst)
    (!pwm_on && !casc && cap1 && !clear1 && !cap1_evt && tick1 &&
     q.cnt1 == `CNT_MAX8)
    |=> (q.flags[`FLG_FIRST_OVF] && q.buf1 == $past(q.dat1)))
    else $error("first overflow not flagged");

  second_match_a: assert property (@(posedge clk) disable iff (rst)
    (!casc && !cap2 && !clear2 && tick2 && q.cnt2 == q.buf2)
    |=> (q.cnt2 == 8'h00 && q.tog2 != $past(q.tog2)))
    else $error("second timer match did not clear and toggle");

  cascade_match_a: assert property (@(posedge clk) disable iff (rst)
    (!pwm_on && casc && !cap1 && !clear1 && tick1 &&
     {q.cnt2, q.cnt1} == {q.buf2, q.buf1})
    |=> ({q.cnt2, q.cnt1} == 16'h0000 && q.flags[`FLG_FIRST_MATCH]))
    else $error("cascaded match did not clear both bytes");

  cascade_ovf_a: assert property (@(posedge clk) disable iff (rst)
    (!pwm_on && casc && cap1 && !clear1 && !cap1_evt && tick1 &&
     {q.cnt2, q.cnt1} == `CNT_MAX16)
    |=> q.flags[`FLG_FIRST_OVF] ##1 q.flags[`FLG_FIRST_OVF] ||
        $past(isr_ack[`FLG_FIRST_OVF]) || $past(wr))
    else $error("cascaded overflow not flagged");

  clear_restart_a: assert property (@(posedge clk) disable iff (rst)
    clear1 |=> (q.cnt1 == 8'h00 && q.buf1 == $past(q.dat1) &&
                !q.ctl1[`CTL_CLEAR]))
    else $error("clear bit did not restart first counter");

  ack_clear_a: assert property (@(posedge clk) disable iff (rst)
    (isr_ack[`FLG_SECOND_MATCH] && !(!casc && !cap2 && !clear2 &&
     tick2 && q.cnt2 == q.buf2))
    |=> !q.flags[`FLG_SECOND_MATCH])
    else $error("service acknowledge did not clear flag");

  duty_hold_a: assert property (@(posedge clk) disable iff (rst)
    (pwm_on && $past(pwm_on) && q.duty_sh != $past(q.duty_sh))
    |-> $past(end_p))
    else $error("duty changed inside a pwm period");

  zero_duty_a: assert property (@(posedge clk) disable iff (rst)
    (pwm_on && $past(pwm_on) && $past(q.duty_sh[29:20]) == 10'h000)
    |-> q.pwm_out[2] == !$past(q.pwm_ctl[`PWM_POL_A + 2]))
    else $error("zero duty channel c not at idle level");

endmodule

// ==== core/dual_timer_consts.svh ====
// constants of the dual timer with pwm: register indices, fields, resets
// assumes apb byte address = 4 * register index, 8-bit data in bits 7:0
//
// Summary of operation
// - first timer match toggles pin, flags, clears
// - first capture copies count, then clears counter
// - first capture mode flags every 8-bit wrap
// - first buffer fetched at clear, match, overflow
// - second timer match toggles pin, flags, clears
// - second capture copies count, then clears counter
// - second capture mode flags every 8-bit wrap
// - second buffer fetched at clear, match, overflow
// - cascaded 16-bit match toggles, flags, clears both
// - cascaded capture copies both bytes, clears both
// - cascaded capture flags every 16-bit wrap
// - cascaded buffer fetches both data bytes
// - cascaded capture edge rising or falling, selectable
// - pwm select bit turns first timer into pwm
// - pwm period is ten-bit value plus one
// - channel duty is ten-bit value plus one
// - polarity bits choose active high or low duty
// - new duty applies after current period ends
// - duty equal period or zero gives constant level
// - clear bit restarts counter and self-clears
// - entering service routine clears request flag
`ifndef DUAL_TIMER_CONSTS_SVH
`define DUAL_TIMER_CONSTS_SVH

// register indices (byte address is four times these)
`define IDX_FIRST_DATA     8'hb8
`define IDX_FIRST_COUNT    8'hb9
`define IDX_SECOND_DATA    8'hba
`define IDX_SECOND_COUNT   8'hbb
`define IDX_FIRST_CTL      8'hc9
`define IDX_PWM_CTL        8'hce
`define IDX_PWM_EXT        8'hcf
`define IDX_DUTY_A         8'hd0
`define IDX_DUTY_B         8'hd1
`define IDX_DUTY_C         8'hd2
`define IDX_SECOND_CTL     8'hd3
`define IDX_IRQ_FLAGS      8'hd4

// reset values
`define RST_DATA           8'hff
`define RST_CTL            8'h00
`define RST_PWM_CTL        4'h0
`define RST_PWM_EXT        8'hff
`define RST_DUTY           8'hff

// timer control fields
`define CTL_CASCADE        7
`define CTL_CAP_FALL       6
`define CTL_CAPTURE        5
`define CTL_CLEAR          4
`define CTL_CS_MSB         3
`define CTL_WMASK          8'hef

// clock select codes
`define CS_EXT_RISE        4'h5
`define CS_EXT_FALL        4'h6
`define CS_SUB             4'h7
// divider exponents for codes 1111..1000, four bits each
`define FIRST_DIV_SHIFTS   32'ha864_3210
`define SECOND_DIV_SHIFTS  32'hb975_4321

// pwm control fields (register bits 7:4 kept in a 4-bit store)
`define PWM_CTL_LSB        4
`define PWM_SEL            0
`define PWM_POL_A          1

// pwm extension fields
`define EXT_PERIOD_LSB     0
`define EXT_DUTY_A_LSB     2
`define EXT_DUTY_B_LSB     4
`define EXT_DUTY_C_LSB     6

// flag bits
`define FLG_FIRST_MATCH    0
`define FLG_FIRST_OVF      1
`define FLG_SECOND_MATCH   2
`define FLG_SECOND_OVF     3

`define CNT_MAX8           8'hff
`define CNT_MAX16          16'hffff

`endif

// ==== core/dual_timer_pkg.sv ====
// types of the dual timer with pwm
// assumes the constants header is included by the design file
package dual_timer_pkg;

  typedef struct packed {
    logic [10:0] presc;
    logic [7:0]  cnt1;
    logic [7:0]  cnt2;
    logic [7:0]  dat1;
    logic [7:0]  dat2;
    logic [7:0]  buf1;
    logic [7:0]  buf2;
    logic [7:0]  ctl1;
    logic [7:0]  ctl2;
    logic [7:0]  pwm_ext;
    logic [7:0]  duty_a;
    logic [7:0]  duty_b;
    logic [7:0]  duty_c;
    logic [3:0]  pwm_ctl;
    logic [3:0]  flags;
    logic        tog1;
    logic        tog2;
    logic [2:0]  pwm_out;
    logic [2:0]  cap1_s;
    logic [2:0]  cap2_s;
    logic [2:0]  eclk_s;
    logic [2:0]  sclk_s;
    logic [9:0]  pwm_cnt;
    logic [29:0] duty_sh;
    logic [31:0] prdata;
    logic        slverr;
  } state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] dat;
    logic [7:0] buf_;
    logic       match;
    logic       ovf;
  } step_t;

endpackage

// ==== tb/pin_partner.sv ====
// pin partner: capture pins and the external and sub count clocks
// assumes the bench calls its tasks from one process, clocked by clk
`timescale 1ns/1ps

module pin_partner
(
  // clock
  input  wire logic clk,
  // pins toward the timer
  output logic      first_capture_in,
  output logic      second_capture_in,
  output logic      first_ext_clock_in,
  output logic      sub_clock_in
);

  // 0 capture a, 1 capture b, 2 ext clock, 3 sub clock; idle low
  logic [3:0] pins = 4'h0;

  assign first_capture_in   = pins[0];
  assign second_capture_in  = pins[1];
  assign first_ext_clock_in = pins[2];
  assign sub_clock_in       = pins[3];

  ////////////////////////////////////////
  task drive(input int b, input logic v);
    @(posedge clk);
    pins[b] <= v;
  endtask

  // slow phases so every level outlasts the pin synchronisers
  task pulse(input int b, input int k);
    repeat (k)
    begin
      repeat (4) @(posedge clk);
      pins[b] <= 1'b1;
      repeat (4) @(posedge clk);
      pins[b] <= 1'b0;
    end
  endtask

endmodule

// ==== tb/test_dual_timer_with_pwm.sv ====
// self-checking bench for the dual timer with pwm
// assumes the design files and pin_partner; clk 200 MHz
`timescale 1ns/1ps
`include "dual_timer_consts.svh"

module test_dual_timer_with_pwm;

  logic        clk = 1'b0;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [9:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  isr_ack;
  logic [3:0]  irq_req;
  logic        cap_a;
  logic        cap_b;
  logic        ext_clk;
  logic        sub_clk;
  logic        tog_a;
  logic        tog_b;
  logic        pa;
  logic        pb;
  logic        pc;
  logic [8:0]  ob;
  logic [31:0] q;
  logic        err;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          last;

  // one vector so the span tasks can watch any output by index
  assign ob = {pc, pb, pa, irq_req, tog_b, tog_a};

  always #2.5 clk = ~clk;

  always @(posedge clk)
    cyc <= cyc + 1;

  dual_timer_with_pwm dut
  (
    .clk                (clk),
    .rst                (rst),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .first_capture_in   (cap_a),
    .second_capture_in  (cap_b),
    .first_ext_clock_in (ext_clk),
    .sub_clock_in       (sub_clk),
    .first_toggle_out   (tog_a),
    .second_toggle_out  (tog_b),
    .chan_a_out         (pa),
    .chan_b_out         (pb),
    .chan_c_out         (pc),
    .isr_ack            (isr_ack),
    .irq_req            (irq_req)
  );

  pin_partner part
  (
    .clk                (clk),
    .first_capture_in   (cap_a),
    .second_capture_in  (cap_b),
    .first_ext_clock_in (ext_clk),
    .sub_clock_in       (sub_clk)
  );

  ////////////////////////////////////////
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask

  task xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask

  task rd(input logic [7:0] i, input logic [7:0] e);
    xfer(1'b0, i, 8'h00);
    chk(q, {24'h0, e});
  endtask

  // extra edge so the cleared flag has landed before anyone looks
  task ack(input int b);
    @(posedge clk);
    isr_ack <= 4'h1 << b;
    @(posedge clk);
    isr_ack <= 4'h0;
    @(posedge clk);
  endtask

  task wchg(input int b);
    logic v;
    int   g;
    v = ob[b];
    g = 0;
    while (ob[b] === v && g < 70000)
    begin
      @(posedge clk);
      g++;
    end
    if (g >= 70000)
    begin
      mismatches++;
      $display("[FAIL] %0t no change on output %0d", $time, b);
    end
    last = cyc;
  endtask

  // set beats clear, so ack again until the flag is really down
  task drop(input int b);
    do
      ack(b - 2);
    while (ob[b] === 1'b1);
  endtask

  // length and level of one span; flags are timed rise to rise
  task len(input int b, output int n, output logic l);
    int s;
    if (b > 1 && b < 6)
      drop(b);
    wchg(b);
    s = last;
    l = ob[b];
    if (b > 1 && b < 6)
      drop(b);
    wchg(b);
    n = last - s;
  endtask

  task cap(input logic [7:0] ci, c, di, input int ck, cp);
    part.drive(cp, c[`CTL_CAP_FALL]);
    repeat (8) @(posedge clk);
    wr(ci, c);
    part.pulse(ck, 5);
    repeat (8) @(posedge clk);
    part.drive(cp, !c[`CTL_CAP_FALL]);
    repeat (8) @(posedge clk);
    rd(di, 8'h05);
    rd(di + 8'h01, 8'h00);
    wr(ci, 8'h00);
    part.drive(cp, 1'b0);
  endtask

  ////////////////////////////////////////
  task t_regs;
    rd(`IDX_FIRST_DATA, `RST_DATA);
    rd(`IDX_SECOND_DATA, `RST_DATA);
    rd(`IDX_FIRST_CTL, `RST_CTL);
    rd(`IDX_PWM_EXT, `RST_PWM_EXT);
    rd(`IDX_DUTY_C, `RST_DUTY);
    rd(`IDX_PWM_CTL, 8'h00);
    wr(`IDX_PWM_CTL, 8'hef);
    rd(`IDX_PWM_CTL, 8'he0);
    wr(`IDX_PWM_CTL, 8'h00);
    xfer(1'b0, 8'h00, 8'h00);
    chk(q, 32'h0);
    chk(err, 1'b1);
  endtask

  task t_int;
    int   n;
    logic l;
    wr(`IDX_FIRST_DATA, 8'h05);
    wr(`IDX_FIRST_CTL, 8'h18);
    rd(`IDX_FIRST_CTL, 8'h08);
    len(0, n, l);
    chk(n, 6);
    len(2, n, l);
    chk(n, 6);
    wr(`IDX_FIRST_DATA, 8'h02);
    len(0, n, l);
    len(0, n, l);
    chk(n, 3);
    wr(`IDX_FIRST_CTL, 8'h00);
    wr(`IDX_SECOND_DATA, 8'h03);
    wr(`IDX_SECOND_CTL, 8'h18);
    len(1, n, l);
    chk(n, 8);
    len(4, n, l);
    chk(n, 8);
    wr(`IDX_SECOND_CTL, 8'h00);
    wr(`IDX_SECOND_DATA, 8'h01);
    wr(`IDX_FIRST_CTL, 8'h98);
    len(0, n, l);
    chk(n, 259);
    len(2, n, l);
    chk(n, 259);
    wr(`IDX_FIRST_CTL, 8'h00);
  endtask

  task t_cap;
    int   n;
    logic l;
    wr(`IDX_FIRST_CTL, 8'h38);
    len(3, n, l);
    chk(n, 256);
    wr(`IDX_FIRST_CTL, 8'h00);
    wr(`IDX_SECOND_CTL, 8'h38);
    len(5, n, l);
    chk(n, 512);
    wr(`IDX_SECOND_CTL, 8'h00);
    cap(`IDX_FIRST_CTL, 8'h35, `IDX_FIRST_DATA, 2, 0);
    cap(`IDX_FIRST_CTL, 8'h36, `IDX_FIRST_DATA, 2, 0);
    cap(`IDX_SECOND_CTL, 8'h37, `IDX_SECOND_DATA, 3, 1);
    cap(`IDX_FIRST_CTL, 8'hf7, `IDX_FIRST_DATA, 3, 0);
    rd(`IDX_SECOND_DATA, 8'h00);
  endtask

  task t_pwm;
    int   n;
    int   s;
    logic l;
    wr(`IDX_FIRST_CTL, 8'h00);
    wr(`IDX_FIRST_DATA, 8'h05);
    wr(`IDX_PWM_EXT, 8'h15);
    wr(`IDX_DUTY_A, 8'h02);
    wr(`IDX_DUTY_B, 8'h05);
    wr(`IDX_DUTY_C, 8'h00);
    wr(`IDX_PWM_CTL, 8'h70);
    wr(`IDX_FIRST_CTL, 8'h08);
    l = 1'b1;
    while (l !== 1'b0)
      len(6, n, l);
    chk(n, 3);
    s = last;
    wr(`IDX_DUTY_A, 8'h00);
    wchg(6);
    chk(last - s, 259);
    chk({pb, pc}, 2'b11);
    len(6, n, l);
    chk(n, 257);
    chk({pb, pc}, 2'b11);
    wr(`IDX_FIRST_DATA, 8'h10);
    wr(`IDX_PWM_CTL, 8'h50);
    len(6, n, l);
    len(6, n, l);
    len(6, n, l);
    chk(n, l ? 16 : 257);
    len(6, n, l);
    chk(n, l ? 16 : 257);
    s = last;
    wchg(6);
    chk(last - s, 16);
    wr(`IDX_PWM_CTL, 8'h00);
    wr(`IDX_FIRST_CTL, 8'h00);
  endtask

  task t_wrap16;
    int s;
    ack(1);
    wr(`IDX_FIRST_CTL, 8'hb8);
    s = cyc;
    wchg(3);
    chk((last - s + 4) / 8, 8192);
  endtask

  ////////////////////////////////////////
  initial
  begin
    rst     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 10'h000;
    pwdata  = 32'h0;
    isr_ack = 4'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_int;
    t_cap;
    t_pwm;
    t_wrap16;
    finish_test;
  end

  // the 16-bit wrap alone needs some 66k cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test;
  end

endmodule
